// ==== core/dis_pkg.sv ====
// Package: register map, field positions and command encodings of the DDR init sequencer
package dis_pkg;
   localparam logic [11:0] DIS_ADDR_MODE = 12'h100;
   localparam logic [11:0] DIS_ADDR_CTRL = 12'h104;
   localparam logic [11:0] DIS_ADDR_STAT = 12'h108;
   // Control fields, bit numbers in lsb-0 order
   localparam int DIS_CTRL_MODE_EN = 31;
   localparam int DIS_CTRL_CKE = 30;
   localparam int DIS_CTRL_SOFT_REF = 2;
   localparam int DIS_CTRL_SOFT_PRE = 1;
   localparam logic [31:0] DIS_CTRL_RW_MASK = 32'hfbf7_2f00;
   localparam logic [31:0] DIS_CTRL_RESET = 32'h0000_0000;
   // Mode register fields, lsb-0
   localparam int DIS_MODE_CMD = 16;
   localparam int DIS_MODE_MA_LO = 17;
   localparam int DIS_MODE_BA_LO = 30;
   localparam int DIS_MODE_DLLRST = 26;
   // Status fields
   localparam int DIS_STAT_BUSY = 0;
   localparam int DIS_STAT_READY = 1;
   localparam int DIS_STAT_READ_OK = 2;
   // Timing and AXI response codes
   localparam int DIS_DLL_CYCLES = 200;
   localparam logic [1:0] DIS_RESP_OKAY = 2'b00;
   localparam logic [1:0] DIS_RESP_SLVERR = 2'b10;

   // Command on the memory bus: {ras_n, cas_n, we_n}
   typedef enum logic [2:0] {
      DIS_CMD_NOP = 3'b111,
      DIS_CMD_PRE = 3'b010,
      DIS_CMD_REF = 3'b001,
      DIS_CMD_LMR = 3'b000
   } dis_cmd_t;

   typedef struct packed {
      logic cke;
      logic [1:0] cs_n;
      dis_cmd_t cmd;
      logic [1:0] ba;
      logic [12:0] ma;
   } dis_mem_t;

   typedef struct packed {
      logic [11:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [11:0] araddr;
      logic arvalid;
      logic rready;
   } dis_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } dis_axi_rsp_t;
endpackage : dis_pkg

// ==== core/dis_cmd_issuer.sv ====
// Command issuer: drives one memory command for a cycle, then NOPs for a hold time
`timescale 1ns/1ps
`default_nettype none
module dis_cmd_issuer #(
   parameter int HOLD_CYCLES = 8
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic start,
   input wire dis_pkg::dis_cmd_t start_cmd,
   input wire logic [1:0] start_ba,
   input wire logic [12:0] start_ma,
   output dis_pkg::dis_cmd_t cmd,
   output logic [1:0] ba,
   output logic [12:0] ma,
   output logic busy
);
   import dis_pkg::*;
   localparam int CW = $clog2(HOLD_CYCLES + 1);
   dis_cmd_t cmd_reg, cmd_next;
   logic [1:0] ba_reg, ba_next;
   logic [12:0] ma_reg, ma_next;
   logic [CW-1:0] cnt_reg, cnt_next;

   always_comb begin
      cmd_next = DIS_CMD_NOP;
      ba_next = 2'h0;
      ma_next = 13'h0;
      cnt_next = cnt_reg;
      if (cnt_reg != '0) begin
         cnt_next = cnt_reg - CW'(1);
      end else if (start) begin
         cmd_next = start_cmd;
         ba_next = start_ba;
         ma_next = start_ma;
         cnt_next = CW'(HOLD_CYCLES);
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cmd_reg <= DIS_CMD_NOP;
         ba_reg <= 2'h0;
         ma_reg <= 13'h0;
         cnt_reg <= '0;
      end else begin
         cmd_reg <= cmd_next;
         ba_reg <= ba_next;
         ma_reg <= ma_next;
         cnt_reg <= cnt_next;
      end
   end

   assign cmd = cmd_reg;
   assign ba = ba_reg;
   assign ma = ma_reg;
   assign busy = (cnt_reg != '0);
endmodule : dis_cmd_issuer
`default_nettype wire

// ==== core/dis_init_seq.sv ====
// DDR init sequencer: AXI4-Lite control and mode registers driving the memory command bus
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dis_init_seq #(
   parameter int HOLD_CYCLES = 8
) (
   input wire logic clock,
   input wire logic resetn,
   input wire dis_pkg::dis_axi_req_t axi_req,
   output dis_pkg::dis_axi_rsp_t axi_rsp,
   output dis_pkg::dis_mem_t mem,
   output logic mem_clk,
   output logic mem_clk_n,
   output logic mem_ready,
   output logic read_allowed
);
   import dis_pkg::*;

   typedef enum logic [2:0] {
      DIS_ST_IDLE = 3'b000,
      DIS_ST_PRE1 = 3'b001,
      DIS_ST_EMR = 3'b010,
      DIS_ST_MR = 3'b011,
      DIS_ST_PRE2 = 3'b100,
      DIS_ST_REFS = 3'b101,
      DIS_ST_DONE = 3'b110
   } dis_state_t;

   // AXI slave state
   logic [11:0] awaddr_reg, awaddr_next;
   logic aw_full_reg, aw_full_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic w_full_reg, w_full_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic awready_reg, wready_reg, arready_reg;
   // Register and sequencing state
   logic [31:0] ctrl_reg, ctrl_next;
   logic cke_reg, cke_next;
   logic clk_reg, clk_n_reg;
   logic [1:0] cs_n_reg, cs_n_next;
   dis_state_t st_reg, st_next;
   logic [1:0] refs_reg, refs_next;
   logic [7:0] dll_cnt_reg, dll_cnt_next;
   logic dll_wait_reg, dll_wait_next;
   logic ready_reg, ready_next;
   logic read_ok_reg, read_ok_next;
   // Issuer handshake
   logic iss_start;
   dis_cmd_t iss_cmd_in, iss_cmd;
   logic [1:0] iss_ba_in, iss_ba;
   logic [12:0] iss_ma_in, iss_ma;
   logic iss_busy;

   logic wr_fire, rd_fire;
   logic [31:0] wmask, ctrl_wr;
   logic mode_en;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{wstrb_reg[i]}};
      end
   end

   assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
   assign rd_fire = axi_req.arvalid && !rvalid_reg;
   assign mode_en = ctrl_reg[DIS_CTRL_MODE_EN];
   assign ctrl_wr = (ctrl_reg & ~wmask) | (wdata_reg & wmask);

   // AXI4-Lite channels
   always_comb begin
      awaddr_next = awaddr_reg;
      aw_full_next = aw_full_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      w_full_next = w_full_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (axi_req.awvalid && !aw_full_reg) begin
         awaddr_next = axi_req.awaddr;
         aw_full_next = 1'b1;
      end
      if (axi_req.wvalid && !w_full_reg) begin
         wdata_next = axi_req.wdata;
         wstrb_next = axi_req.wstrb;
         w_full_next = 1'b1;
      end
      if (wr_fire) begin
         aw_full_next = 1'b0;
         w_full_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = (awaddr_reg == DIS_ADDR_MODE || awaddr_reg == DIS_ADDR_CTRL ||
            awaddr_reg == DIS_ADDR_STAT) ? DIS_RESP_OKAY : DIS_RESP_SLVERR;
      end else if (bvalid_reg && axi_req.bready) begin
         bvalid_next = 1'b0;
      end
      if (rd_fire) begin
         rvalid_next = 1'b1;
         rresp_next = DIS_RESP_OKAY;
         unique case (axi_req.araddr)
            DIS_ADDR_MODE: rdata_next = 32'h0;
            DIS_ADDR_CTRL: rdata_next = ctrl_reg;
            DIS_ADDR_STAT: begin
               rdata_next = 32'h0;
               rdata_next[DIS_STAT_BUSY] = iss_busy;
               rdata_next[DIS_STAT_READY] = ready_reg;
               rdata_next[DIS_STAT_READ_OK] = read_ok_reg;
            end
            default: begin
               rdata_next = 32'h0;
               rresp_next = DIS_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && axi_req.rready) begin
         rvalid_next = 1'b0;
      end
   end

   // Register writes and command triggers
   always_comb begin
      ctrl_next = ctrl_reg;
      iss_start = 1'b0;
      iss_cmd_in = DIS_CMD_NOP;
      iss_ba_in = 2'h0;
      iss_ma_in = 13'h0;
      if (wr_fire && awaddr_reg == DIS_ADDR_CTRL) begin
         ctrl_next = ctrl_wr & DIS_CTRL_RW_MASK;
         // Triggers act only when unlocked, the memory is awake and no command is in flight
         if (mode_en && cke_reg && !iss_busy) begin
            if (ctrl_wr[DIS_CTRL_SOFT_PRE]) begin
               iss_start = 1'b1;
               iss_cmd_in = DIS_CMD_PRE;
               iss_ma_in[10] = 1'b1;
            end else if (ctrl_wr[DIS_CTRL_SOFT_REF]) begin
               iss_start = 1'b1;
               iss_cmd_in = DIS_CMD_REF;
            end
         end
      end else if (wr_fire && awaddr_reg == DIS_ADDR_MODE) begin
         if (mode_en && cke_reg && !iss_busy && wdata_reg[DIS_MODE_CMD]) begin
            iss_start = 1'b1;
            iss_cmd_in = DIS_CMD_LMR;
            iss_ba_in = wdata_reg[DIS_MODE_BA_LO +: 2];
            iss_ma_in = {1'b0, wdata_reg[DIS_MODE_MA_LO +: 12]};
         end
      end
   end

   // Clock enable, chip selects and init progress
   always_comb begin
      cke_next = ctrl_reg[DIS_CTRL_CKE];
      cs_n_next = iss_start ? 2'b00 : 2'b11;
      st_next = st_reg;
      refs_next = refs_reg;
      ready_next = ready_reg;
      dll_wait_next = dll_wait_reg;
      dll_cnt_next = dll_cnt_reg;
      read_ok_next = read_ok_reg;
      if (dll_wait_reg) begin
         if (dll_cnt_reg == 8'(DIS_DLL_CYCLES - 1)) begin
            dll_wait_next = 1'b0;
            read_ok_next = 1'b1;
         end else begin
            dll_cnt_next = dll_cnt_reg + 8'h1;
         end
      end
      if (iss_start) begin
         unique case (st_reg)
            DIS_ST_IDLE: if (iss_cmd_in == DIS_CMD_PRE) st_next = DIS_ST_PRE1;
            DIS_ST_PRE1: if (iss_cmd_in == DIS_CMD_LMR) st_next = DIS_ST_EMR;
            DIS_ST_EMR: if (iss_cmd_in == DIS_CMD_LMR && iss_ma_in[8]) st_next = DIS_ST_MR;
            DIS_ST_MR: begin
               if (iss_cmd_in == DIS_CMD_PRE) st_next = DIS_ST_PRE2;
               if (iss_cmd_in == DIS_CMD_REF) refs_next = refs_reg + 2'h1;
            end
            DIS_ST_PRE2: if (iss_cmd_in == DIS_CMD_REF) refs_next = refs_reg + 2'h1;
            DIS_ST_REFS: ;
            DIS_ST_DONE: ;
            default: st_next = DIS_ST_IDLE;
         endcase
         if (st_reg == DIS_ST_PRE2 && refs_reg >= 2'h1 && iss_cmd_in == DIS_CMD_REF) begin
            st_next = DIS_ST_REFS;
         end
         if (st_reg == DIS_ST_PRE2 && refs_reg >= 2'h2 && iss_cmd_in == DIS_CMD_LMR) begin
            st_next = DIS_ST_DONE;
         end
         if (st_reg == DIS_ST_REFS && iss_cmd_in == DIS_CMD_LMR && !iss_ma_in[8]) begin
            st_next = DIS_ST_DONE;
         end
         if (iss_cmd_in == DIS_CMD_LMR && iss_ma_in[8]) begin
            dll_wait_next = 1'b1;
            dll_cnt_next = 8'h0;
            read_ok_next = 1'b0;
         end
      end
      // Ready after final load and its hold time
      if (st_reg == DIS_ST_DONE && !iss_busy && !iss_start) begin
         ready_next = 1'b1;
      end
      if (!cke_reg) begin
         ready_next = 1'b0;
      end
   end

   dis_cmd_issuer #(
      .HOLD_CYCLES(HOLD_CYCLES)
   ) u_issuer (
      .clock(clock),
      .resetn(resetn),
      .start(iss_start),
      .start_cmd(iss_cmd_in),
      .start_ba(iss_ba_in),
      .start_ma(iss_ma_in),
      .cmd(iss_cmd),
      .ba(iss_ba),
      .ma(iss_ma),
      .busy(iss_busy)
   );

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         awaddr_reg <= 12'h0;
         aw_full_reg <= 1'b0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         w_full_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= DIS_RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= DIS_RESP_OKAY;
         ctrl_reg <= DIS_CTRL_RESET;
         cke_reg <= 1'b0;
         cs_n_reg <= 2'b11;
         st_reg <= DIS_ST_IDLE;
         refs_reg <= 2'h0;
         dll_cnt_reg <= 8'h0;
         dll_wait_reg <= 1'b0;
         ready_reg <= 1'b0;
         read_ok_reg <= 1'b0;
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         arready_reg <= 1'b1;
      end else begin
         awaddr_reg <= awaddr_next;
         aw_full_reg <= aw_full_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         w_full_reg <= w_full_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         ctrl_reg <= ctrl_next;
         cke_reg <= cke_next;
         cs_n_reg <= cs_n_next;
         st_reg <= st_next;
         refs_reg <= refs_next;
         dll_cnt_reg <= dll_cnt_next;
         dll_wait_reg <= dll_wait_next;
         ready_reg <= ready_next;
         read_ok_reg <= read_ok_next;
         awready_reg <= !aw_full_next;
         wready_reg <= !w_full_next;
         arready_reg <= !rvalid_next;
      end
   end

   // Free-running memory clock at half the system rate
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         clk_reg <= 1'b0;
         clk_n_reg <= 1'b1;
      end else begin
         clk_reg <= ~clk_reg;
         clk_n_reg <= clk_reg;
      end
   end

   assign axi_rsp.awready = awready_reg;
   assign axi_rsp.wready = wready_reg;
   assign axi_rsp.bvalid = bvalid_reg;
   assign axi_rsp.bresp = bresp_reg;
   assign axi_rsp.arready = arready_reg;
   assign axi_rsp.rvalid = rvalid_reg;
   assign axi_rsp.rdata = rdata_reg;
   assign axi_rsp.rresp = rresp_reg;
   assign mem.cke = cke_reg;
   assign mem.cs_n = cs_n_reg;
   assign mem.cmd = iss_cmd;
   assign mem.ba = iss_ba;
   assign mem.ma = iss_ma;
   assign mem_clk = clk_reg;
   assign mem_clk_n = clk_n_reg;
   assign mem_ready = ready_reg;
   assign read_allowed = read_ok_reg;
endmodule : dis_init_seq
`default_nettype wire

// ==== verification/dis_ddr_model.sv ====
// Memory-side model: counts commands and flags bus breaches
`timescale 1ns/1ps
`default_nettype none
module dis_ddr_model #(
   parameter int HOLD_CYCLES = 8
) (
   input wire logic clock,
   input wire logic resetn,
   input wire dis_pkg::dis_mem_t mem,
   output logic [7:0] cnt,
   output dis_pkg::dis_cmd_t last_cmd,
   output logic [1:0] last_ba,
   output logic [12:0] last_ma,
   output logic [7:0] viol
);
   import dis_pkg::*;
   logic [7:0] gap;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt <= 8'h00;
         last_cmd <= DIS_CMD_NOP;
         last_ba <= 2'h0;
         last_ma <= 13'h0000;
         viol <= 8'h00;
         gap <= 8'hff;
      end else if (mem.cs_n != 2'b11 && mem.cmd != DIS_CMD_NOP) begin
         cnt <= cnt + 8'h01;
         last_cmd <= mem.cmd;
         last_ba <= mem.ba;
         last_ma <= mem.ma;
         gap <= 8'h00;
         if (!mem.cke || gap < 8'(HOLD_CYCLES) || (mem.cmd == DIS_CMD_LMR && mem.ba == 2'b01
               && (mem.ma & 13'h1ffd) != 13'h0000)) begin
            viol <= viol + 8'h01;
         end
      end else if (gap != 8'hff) begin
         gap <= gap + 8'h01;
      end
   end
endmodule : dis_ddr_model
`default_nettype wire

// ==== verification/dis_init_seq_assertions.sv ====
// Checker: port properties of the DDR init sequencer
`timescale 1ns/1ps
`default_nettype none
module dis_init_seq_chk #(
   parameter int HOLD_CYCLES = 8
) (
   input wire logic clock,
   input wire logic resetn,
   input wire dis_pkg::dis_axi_req_t axi_req,
   input wire dis_pkg::dis_axi_rsp_t axi_rsp,
   input wire dis_pkg::dis_mem_t mem,
   input wire logic mem_clk,
   input wire logic mem_clk_n,
   input wire logic mem_ready,
   input wire logic read_allowed
);
   import dis_pkg::*;
   logic cmd_on;
   logic [7:0] gap_reg;
   logic [7:0] gap_next;
   logic [15:0] dll_reg;
   logic [15:0] dll_next;
   logic [11:0] rd_reg;
   logic [11:0] rd_next;
   assign cmd_on = mem.cmd != DIS_CMD_NOP;
   always_comb begin
      gap_next = cmd_on ? 8'h00 : gap_reg + {7'h00, gap_reg != 8'hff};
      dll_next = dll_reg + {15'h0000, dll_reg != 16'h0000 && dll_reg != 16'hffff};
      if (mem.cmd == DIS_CMD_LMR && mem.ba == 2'b00 && mem.ma[8]) begin
         dll_next = 16'h0001;
      end
      rd_next = (axi_req.arvalid && axi_rsp.arready) ? axi_req.araddr : rd_reg;
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         gap_reg <= 8'hff;
         dll_reg <= 16'h0000;
         rd_reg <= 12'h000;
      end else begin
         gap_reg <= gap_next;
         dll_reg <= dll_next;
         rd_reg <= rd_next;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   property p_clk_run;
      $past(resetn) |-> mem_clk != $past(mem_clk) && mem_clk_n == !mem_clk;
   endproperty
   property p_cs_all; (mem.cs_n == 2'b00) == cmd_on; endproperty
   property p_cke_cmd; cmd_on |-> mem.cke; endproperty
   property p_cause; cmd_on |-> $rose(axi_rsp.bvalid); endproperty
   property p_spacing; cmd_on |-> gap_reg >= HOLD_CYCLES; endproperty
   property p_ready_hold; mem_ready |=> mem_ready; endproperty
   property p_read_early; $rose(read_allowed) |-> dll_reg >= 16'd200; endproperty
   property p_read_late; dll_reg == 16'd205 |-> read_allowed; endproperty
   property p_trig_zero;
      axi_rsp.rvalid && rd_reg == DIS_ADDR_CTRL |-> axi_rsp.rdata[2:1] == 2'b00;
   endproperty
   a_clk_run: assert property (p_clk_run) else $error("memory clock stalled");
   a_cs_all: assert property (p_cs_all) else $error("chip selects wrong");
   a_cke_cmd: assert property (p_cke_cmd) else $error("command with cke low");
   a_cause: assert property (p_cause) else $error("command without write");
   a_spacing: assert property (p_spacing) else $error("commands too close");
   a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
   a_read_early: assert property (p_read_early) else $error("read allowed early");
   a_read_late: assert property (p_read_late) else $error("read not allowed");
   a_trig_zero: assert property (p_trig_zero) else $error("trigger reads one");
   c_lmr: cover property (mem.cmd == DIS_CMD_LMR);
   c_ref: cover property (mem.cmd == DIS_CMD_REF);
   c_ready: cover property ($rose(mem_ready));
endmodule : dis_init_seq_chk
bind dis_init_seq dis_init_seq_chk #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (.clock(clock),
   .resetn(resetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .mem(mem), .mem_clk(mem_clk),
   .mem_clk_n(mem_clk_n), .mem_ready(mem_ready), .read_allowed(read_allowed));
`default_nettype wire

// ==== verification/tb_dis_init_seq.sv ====
// Testbench: init sequence, register access and refusals of the DDR init sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_dis_init_seq;
   import dis_pkg::*;
   localparam int HOLD = 8;
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] data;
      dis_cmd_t cmd;
   } dis_row_t;
   logic clock;
   logic resetn;
   dis_axi_req_t req;
   dis_axi_rsp_t rsp;
   dis_mem_t mem;
   logic mem_clk;
   logic mem_ready;
   logic read_allowed;
   logic [7:0] cnt;
   dis_cmd_t last_cmd;
   logic [1:0] last_ba;
   logic [12:0] last_ma;
   logic [7:0] viol;
   logic [1:0] resp;
   logic [31:0] rd;
   logic [7:0] c0;
   int err_count;
   int checks_done;
   dis_row_t rows [8];
   int ord [8];
   dis_init_seq #(.HOLD_CYCLES(HOLD)) dut (.clock(clock), .resetn(resetn), .axi_req(req),
      .axi_rsp(rsp), .mem(mem), .mem_clk(mem_clk), .mem_clk_n(), .mem_ready(mem_ready),
      .read_allowed(read_allowed));
   dis_ddr_model #(.HOLD_CYCLES(HOLD)) u_mem (.clock(clock), .resetn(resetn), .mem(mem),
      .cnt(cnt), .last_cmd(last_cmd), .last_ba(last_ba), .last_ma(last_ma), .viol(viol));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      end while (!(req.bready && rsp.bvalid) && n < 100);
      resp = rsp.bresp;
      req.bready <= 1'b0;
      if (n >= 100) begin
         err_count++;
         conclude();
      end
   endtask : wr
   task automatic rdr(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge clock);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      end while (!(req.rready && rsp.rvalid) && n < 100);
      rd = rsp.rdata;
      resp = rsp.rresp;
      req.rready <= 1'b0;
      if (n >= 100) begin
         err_count++;
         conclude();
      end
   endtask : rdr
   task automatic play(input int i);
      c0 = cnt;
      wr(rows[i].addr, rows[i].data);
      repeat (HOLD + 4) @(posedge clock);
      check(32'(resp), 32'(DIS_RESP_OKAY));
      check(32'(cnt - c0), 32'(rows[i].cmd != DIS_CMD_NOP));
      if (rows[i].cmd != DIS_CMD_NOP) check(32'(last_cmd), 32'(rows[i].cmd));
      if (rows[i].cmd == DIS_CMD_LMR) begin
         check({17'h0, last_ba, last_ma}, {17'h0, rows[i].data[DIS_MODE_BA_LO +: 2], 1'b0,
            rows[i].data[DIS_MODE_MA_LO +: 12]});
      end
   endtask : play
   initial begin
      req = '0;
      resetn = 1'b0;
      err_count = 0;
      checks_done = 0;
      rows[0] = '{DIS_ADDR_CTRL, 32'hc000_0000, DIS_CMD_NOP};
      rows[1] = '{DIS_ADDR_CTRL, 32'hc000_0002, DIS_CMD_PRE};
      rows[2] = '{DIS_ADDR_MODE, 32'h4001_0000, DIS_CMD_LMR};
      rows[3] = '{DIS_ADDR_MODE, 32'h02c7_0000, DIS_CMD_LMR};
      rows[4] = '{DIS_ADDR_CTRL, 32'hc000_0002, DIS_CMD_PRE};
      rows[5] = '{DIS_ADDR_CTRL, 32'hc000_0004, DIS_CMD_REF};
      rows[6] = '{DIS_ADDR_CTRL, 32'hc000_0004, DIS_CMD_REF};
      rows[7] = '{DIS_ADDR_MODE, 32'h00c7_0000, DIS_CMD_LMR};
      // Refreshes ahead of the second precharge
      ord = '{0, 1, 2, 3, 5, 6, 4, 7};
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      check(32'(mem.cke), 32'h0);
      check(32'(mem.cmd), 32'(DIS_CMD_NOP));
      wr(DIS_ADDR_MODE, 32'h4001_0000);
      check(32'(cnt), 32'h0);
      // Settle time before enabling
      repeat (4000) @(posedge clock);
      check(32'(mem.cke), 32'h0);
      foreach (rows[i]) begin
         play(i);
      end
      check(32'(mem.cke), 32'h1);
      check(32'(mem_ready), 32'h1);
      check(32'(read_allowed), 32'h0);
      repeat (200) @(posedge clock);
      check(32'(read_allowed), 32'h1);
      // Second trigger while busy
      c0 = cnt;
      wr(DIS_ADDR_CTRL, 32'hc000_0002);
      wr(DIS_ADDR_CTRL, 32'hc000_0004);
      repeat (HOLD + 4) @(posedge clock);
      check(32'(cnt - c0), 32'h1);
      check(32'(last_cmd), 32'(DIS_CMD_PRE));
      rdr(DIS_ADDR_CTRL);
      check(rd, 32'hc000_0004 & DIS_CTRL_RW_MASK);
      rdr(DIS_ADDR_STAT);
      check(rd, {29'h0, 3'b110});
      rdr(12'h10c);
      check(rd, 32'h0);
      check(32'(resp), 32'(DIS_RESP_SLVERR));
      wr(12'h10c, 32'h1);
      check(32'(resp), 32'(DIS_RESP_SLVERR));
      // Locked: mode write and refresh trigger must stay off the bus
      wr(DIS_ADDR_CTRL, 32'h4000_0000);
      c0 = cnt;
      wr(DIS_ADDR_MODE, 32'h0001_0000);
      wr(DIS_ADDR_CTRL, 32'h4000_0004);
      repeat (HOLD + 4) @(posedge clock);
      check(32'(cnt - c0), 32'h0);
      check(32'(viol), 32'h0);
      // Mid-run reset, then the sequence with early refreshes
      @(posedge clock);
      resetn <= 1'b0;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      check(32'(mem.cke), 32'h0);
      check(32'(mem_ready), 32'h0);
      check(32'(read_allowed), 32'h0);
      foreach (ord[i]) begin
         play(ord[i]);
         if (i < 7) check(32'(mem_ready), 32'h0);
      end
      check(32'(mem_ready), 32'h1);
      check(32'(viol), 32'h0);
      conclude();
   end
endmodule : tb_dis_init_seq
`default_nettype wire
